// *** hdl/bit_unit_pkg.sv ***
package bit_unit_pkg;

    localparam int BYTE_W      = 8;
    localparam int POS_W       = 3;
    localparam int OP_W        = 9;
    localparam int CC_W        = 2;
    localparam int FLAG_W      = 4;
    // flag field positions in the flag word
    localparam int FLAG_C_POS  = 0;
    localparam int FLAG_V_POS  = 1;
    localparam int FLAG_Z_POS  = 2;
    localparam int FLAG_N_POS  = 3;
    localparam logic [BYTE_W-1:0] DATA_RST  = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
    localparam logic [POS_W-1:0]  POS_RST   = 3'h0;

    // one-hot operation codes, except OP_NONE which is all zeros
    typedef enum logic [OP_W-1:0] {
        OP_NONE       = 9'h000,
        OP_SET        = 9'h001,
        OP_COND_SET   = 9'h002,
        OP_CLEAR      = 9'h004,
        OP_COND_CLEAR = 9'h008,
        OP_INVERT     = 9'h010,
        OP_TEST       = 9'h020,
        OP_CARRY_AND  = 9'h040,
        OP_CARRY_ANDN = 9'h080,
        OP_CARRY_OR   = 9'h100
    } bit_op_e;

    // condition choice for the conditional operations
    typedef enum logic [CC_W-1:0] {
        CC_Z_SET   = 2'h1,
        CC_Z_CLEAR = 2'h2
    } cond_e;

    typedef struct packed {
        logic                 valid;
        bit_op_e              op;
        logic                 pos_from_reg;
        logic [POS_W-1:0]     pos_imm;
        logic [BYTE_W-1:0]    pos_reg;
        cond_e                cond;
        logic                 dst_is_mem;
        logic [BYTE_W-1:0]    operand;
        logic [FLAG_W-1:0]    flags;
    } bit_req_s;

    typedef struct packed {
        logic                 done;
        logic                 reg_we;
        logic                 mem_we;
        logic [BYTE_W-1:0]    result;
        logic [FLAG_W-1:0]    flags;
        logic                 bad_op;
    } bit_rsp_s;

endpackage

// *** hdl/bit_select.sv ***
`timescale 1ns/1ps
module bit_select #(
    parameter int W = bit_unit_pkg::BYTE_W
) (
    input  wire logic [W-1:0]           data,
    input  wire logic [$clog2(W)-1:0]   pos,
    output logic                        bit_val,
    output logic      [W-1:0]           mask
);
    import bit_unit_pkg::*;

    initial begin
        if (W < 2) $error("bit_select width too small");
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_dec
            assign mask[i] = (int'(pos) == i);
        end
    endgenerate

    // position zero is the least significant bit
    assign bit_val = |(data & mask);
endmodule

// *** hdl/bit_manipulation_unit.sv ***
`timescale 1ns/1ps
module bit_manipulation_unit #(
    parameter int DATA_W = bit_unit_pkg::BYTE_W
) (
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    input  wire bit_unit_pkg::bit_req_s  req,
    output bit_unit_pkg::bit_rsp_s       rsp
);
    import bit_unit_pkg::*;

    // package constants must suit the byte datapath
    initial begin
        if (DATA_W != BYTE_W) begin
            $error("bit unit serves byte operands only");
        end
        if (POS_W != $clog2(BYTE_W)) begin
            $error("bit position width does not match the byte");
        end
        if (FLAG_C_POS >= FLAG_W || FLAG_Z_POS >= FLAG_W) begin
            $error("carry or zero flag lies outside the flag word");
        end
        if (FLAG_V_POS >= FLAG_W || FLAG_N_POS >= FLAG_W) begin
            $error("overflow or sign flag lies outside the flag word");
        end
        if (FLAG_C_POS == FLAG_Z_POS) begin
            $error("carry and zero flags share a position");
        end
        if (FLAG_V_POS == FLAG_N_POS) begin
            $error("overflow and sign flags share a position");
        end
        if (FLAG_C_POS == FLAG_V_POS || FLAG_C_POS == FLAG_N_POS
            || FLAG_Z_POS == FLAG_V_POS || FLAG_Z_POS == FLAG_N_POS) begin
            $error("carry or zero flag shares a position with another flag");
        end
    end

    logic [POS_W-1:0]  pos;
    logic              sel_bit;
    logic [BYTE_W-1:0] mask;
    logic              z_now;
    logic              cond_ok;
    logic              carry_op;
    logic [BYTE_W-1:0] result_d;
    logic [FLAG_W-1:0] flags_d;
    logic              reg_we_d;
    logic              mem_we_d;
    logic              bad_d;
    logic              done_q;
    logic              reg_we_q;
    logic              mem_we_q;
    logic              bad_q;
    logic [BYTE_W-1:0] result_q;
    logic [FLAG_W-1:0] flags_q;

    always_comb begin
        case (req.op)
            OP_CARRY_AND:  carry_op = 1'h1;
            OP_CARRY_ANDN: carry_op = 1'h1;
            OP_CARRY_OR:   carry_op = 1'h1;
            default:       carry_op = 1'h0;
        endcase
    end

    // carry ops ignore the register source so a stray select cannot steer them
    always_comb begin
        if (req.pos_from_reg && !carry_op) begin
            pos = req.pos_reg[POS_W-1:0];
        end else begin
            pos = req.pos_imm;
        end
    end

    bit_select #(
        .W (BYTE_W)
    ) u_sel (
        .data    (req.operand),
        .pos     (pos),
        .bit_val (sel_bit),
        .mask    (mask)
    );

    assign z_now = req.flags[FLAG_Z_POS];

    always_comb begin
        case (req.cond)
            CC_Z_SET:   cond_ok = z_now;
            CC_Z_CLEAR: cond_ok = !z_now;
            default:    cond_ok = 1'h0;
        endcase
    end

    always_comb begin
        result_d = req.operand;
        flags_d  = req.flags;
        reg_we_d = 1'h0;
        mem_we_d = 1'h0;
        bad_d    = 1'h0;
        case (req.op)
            OP_SET: begin
                result_d = req.operand | mask;
                reg_we_d = !req.dst_is_mem;
                mem_we_d = req.dst_is_mem;
            end
            OP_CLEAR: begin
                result_d = req.operand & ~mask;
                reg_we_d = !req.dst_is_mem;
                mem_we_d = req.dst_is_mem;
            end
            OP_INVERT: begin
                result_d = req.operand ^ mask;
                reg_we_d = !req.dst_is_mem;
                mem_we_d = req.dst_is_mem;
            end
            OP_COND_SET: begin
                // memory only; a register destination is flagged, not written
                result_d = req.operand | mask;
                mem_we_d = req.dst_is_mem && cond_ok;
                bad_d    = !req.dst_is_mem;
            end
            OP_COND_CLEAR: begin
                result_d = req.operand & ~mask;
                mem_we_d = req.dst_is_mem && cond_ok;
                bad_d    = !req.dst_is_mem;
            end
            OP_TEST: begin
                flags_d[FLAG_Z_POS] = !sel_bit;
            end
            OP_CARRY_AND: begin
                flags_d[FLAG_C_POS] = req.flags[FLAG_C_POS] & sel_bit;
            end
            OP_CARRY_ANDN: begin
                flags_d[FLAG_C_POS] = req.flags[FLAG_C_POS] & !sel_bit;
            end
            OP_CARRY_OR: begin
                flags_d[FLAG_C_POS] = req.flags[FLAG_C_POS] | sel_bit;
            end
            OP_NONE: begin
                // an empty slot completes with nothing written and nothing refused
                bad_d = 1'h0;
            end
            default: begin
                bad_d = 1'h1;
            end
        endcase
    end

    // strobes stand one cycle, the core acts on them at once
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            done_q <= 1'h0;
        end else begin
            done_q <= req.valid;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_we_q <= 1'h0;
        end else begin
            reg_we_q <= req.valid && reg_we_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mem_we_q <= 1'h0;
        end else begin
            mem_we_q <= req.valid && mem_we_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bad_q <= 1'h0;
        end else begin
            bad_q <= req.valid && bad_d;
        end
    end

    // result and flags hold between requests so the core may take them late
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            result_q <= DATA_RST;
        end else if (req.valid) begin
            result_q <= result_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flags_q <= FLAGS_RST;
        end else if (req.valid) begin
            flags_q <= flags_d;
        end
    end

    // every response field comes straight from its own flip-flop
    assign rsp = '{
        done:   done_q,
        reg_we: reg_we_q,
        mem_we: mem_we_q,
        result: result_q,
        flags:  flags_q,
        bad_op: bad_q
    };

endmodule

// *** dv/bit_manipulation_unit_props.sv ***
`timescale 1ns/1ps
module bit_manipulation_unit_props (
    input wire logic                   sys_clk,
    input wire logic                   sys_rst,
    input wire bit_unit_pkg::bit_req_s req,
    input wire bit_unit_pkg::bit_rsp_s rsp
);
    import bit_unit_pkg::*;
    bit_req_s   r_q;
    bit_op_e    o;
    logic [7:0] d, m;
    logic [3:0] f;
    logic       c, hit;
    always_ff @(posedge sys_clk) r_q <= req;
    assign o = rsp.done ? r_q.op : OP_NONE;
    assign d = r_q.operand;
    assign f = r_q.flags;
    assign m = 8'h01 << (r_q.pos_from_reg ? r_q.pos_reg[2:0] : r_q.pos_imm);
    assign c = d[r_q.pos_imm];
    // judged on the flag handed in, not the one produced
    assign hit = r_q.cond == CC_Z_SET ? f[FLAG_Z_POS] : r_q.cond == CC_Z_CLEAR && !f[FLAG_Z_POS];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_set; o == OP_SET |-> rsp.result == (d | m); endproperty
    a_set: assert property (p_set) else $error("set result");
    property p_clr; o == OP_CLEAR |-> rsp.result == (d & ~m); endproperty
    a_clr: assert property (p_clr) else $error("clear result");
    property p_inv; o == OP_INVERT |-> rsp.result == (d ^ m) && rsp.flags == f; endproperty
    a_inv: assert property (p_inv) else $error("invert result");
    property p_tst; o == OP_TEST |-> rsp.flags == {f[3], ~|(d & m), f[1:0]} && !rsp.mem_we;
    endproperty
    a_tst: assert property (p_tst) else $error("test flag");
    property p_and; o == OP_CARRY_AND |-> rsp.flags == {f[3:1], f[0] & c}; endproperty
    a_and: assert property (p_and) else $error("carry and");
    property p_andn; o == OP_CARRY_ANDN |-> rsp.flags == {f[3:1], f[0] & !c}; endproperty
    a_andn: assert property (p_andn) else $error("carry and inverted");
    property p_or; o == OP_CARRY_OR |-> rsp.flags == {f[3:1], f[0] | c}; endproperty
    a_or: assert property (p_or) else $error("carry or");
    property p_cnd; (o == OP_COND_SET || o == OP_COND_CLEAR) && r_q.dst_is_mem
        |-> rsp.mem_we == hit; endproperty
    a_cnd: assert property (p_cnd) else $error("conditional write");
endmodule

bind bit_manipulation_unit bit_manipulation_unit_props u_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .rsp(rsp));

// *** dv/bit_manipulation_unit_bench.sv ***
`timescale 1ns/1ps
module bit_manipulation_unit_bench;
    import bit_unit_pkg::*;
    logic     sys_clk = 0;
    logic     sys_rst = 1;
    bit_req_s req = '0;
    bit_rsp_s rsp;
    int       failures = 0;
    int       tests_run = 0;
    always #50 sys_clk = ~sys_clk;
    bit_manipulation_unit dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .rsp(rsp));
    task chk(logic [7:0] s, logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    // idle cycle first so valid never toggles twice in one step
    task go(bit_op_e o, logic [7:0] d, logic [3:0] f);
        @(negedge sys_clk);
        req.op = o;
        req.operand = d;
        req.flags = f;
        req.valid = 1;
        @(negedge sys_clk);
        req.valid = 0;
    endtask
    task cy(bit_op_e o, logic [7:0] d, logic [3:0] f, logic [3:0] e);
        go(o, d, f);
        chk(8'({rsp.mem_we, rsp.reg_we, rsp.flags}), 8'(e));
    endtask
    task t_bits;
        for (int p = 0; p < 8; p++) begin
            req.pos_imm = 3'(p);
            req.dst_is_mem = 1;
            go(OP_SET, 8'h00, 4'ha);
            chk(rsp.result, 8'h01 << p);
            chk(8'({rsp.done, rsp.mem_we, rsp.reg_we, rsp.flags}), 8'h6a);
            req.dst_is_mem = 0;
            go(OP_CLEAR, 8'hff, 4'h5);
            chk(rsp.result, ~(8'h01 << p));
            chk(8'({rsp.done, rsp.mem_we, rsp.reg_we, rsp.flags}), 8'h55);
            go(OP_INVERT, 8'h5a, 4'h0);
            chk(rsp.result, 8'h5a ^ (8'h01 << p));
        end
    endtask
    task t_regpos;
        req.pos_from_reg = 1;
        req.pos_reg = 8'hfd;
        req.pos_imm = 3'h0;
        go(OP_SET, 8'h00, 4'h0);
        chk(rsp.result, 8'h20);
        cy(OP_CARRY_OR, 8'h01, 4'h0, 4'h1);
        req.pos_from_reg = 0;
    endtask
    task t_flags;
        req.pos_imm = 3'h6;
        cy(OP_TEST, 8'hbf, 4'h9, 4'hd);
        cy(OP_TEST, 8'h40, 4'hf, 4'hb);
        cy(OP_CARRY_AND, 8'h40, 4'hf, 4'hf);
        cy(OP_CARRY_AND, 8'hbf, 4'hf, 4'he);
        cy(OP_CARRY_ANDN, 8'hbf, 4'h1, 4'h1);
        cy(OP_CARRY_ANDN, 8'h40, 4'h1, 4'h0);
        cy(OP_CARRY_OR, 8'h40, 4'h6, 4'h7);
        cy(OP_CARRY_OR, 8'hbf, 4'h6, 4'h6);
    endtask
    task t_cond;
        req.pos_imm = 3'h2;
        req.dst_is_mem = 1;
        req.cond = CC_Z_SET;
        go(OP_COND_SET, 8'h00, 4'h4);
        chk({rsp.mem_we, rsp.result[6:0]}, 8'h84);
        go(OP_COND_SET, 8'h00, 4'h0);
        chk(8'(rsp.mem_we), 8'h00);
        req.cond = CC_Z_CLEAR;
        go(OP_COND_CLEAR, 8'hff, 4'h0);
        chk({rsp.mem_we, rsp.result[6:0]}, 8'hfb);
        go(OP_COND_CLEAR, 8'hff, 4'h4);
        chk(8'(rsp.mem_we), 8'h00);
        req.dst_is_mem = 0;
        go(OP_COND_SET, 8'h00, 4'h0);
        chk(8'({rsp.bad_op, rsp.mem_we, rsp.reg_we}), 8'h04);
    endtask
    task t_refuse;
        req.dst_is_mem = 1;
        req.cond = cond_e'(2'h0);
        go(OP_COND_SET, 8'h00, 4'h4);
        chk(8'({rsp.done, rsp.bad_op, rsp.mem_we, rsp.reg_we}), 8'h08);
        go(bit_op_e'(9'h003), 8'h3c, 4'h9);
        chk(8'({rsp.bad_op, rsp.mem_we, rsp.reg_we, rsp.flags}), 8'h49);
        @(negedge sys_clk);
        chk(8'({rsp.done, rsp.bad_op, rsp.mem_we, rsp.reg_we}), 8'h00);
        chk(rsp.result, 8'h3c);
    endtask
    task final_report;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #50000;
        failures++;
        final_report();
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        sys_rst = 0;
        t_bits();
        t_regpos();
        t_flags();
        t_cond();
        t_refuse();
        final_report();
    end
endmodule
